// File: shared/flash_timing_pkg.sv
// Shared constants and types for the flash program/erase timing block
package flash_timing_pkg;

    localparam int DIV_W           = 8;
    localparam int BUS_CNT_W       = 5;
    localparam int OP_CNT_W        = 15;
    localparam int ADDR_W          = 17;

    // Durations in bus clock cycles and operation clock ticks, and the burst, erase pulse and blank-check counts
    localparam logic [BUS_CNT_W-1:0] SWORD_BUS_CYCLES = 5'h19;
    localparam logic [OP_CNT_W-1:0]  SWORD_OP_TICKS   = 15'h0009;
    localparam logic [BUS_CNT_W-1:0] BWORD_BUS_CYCLES = 5'h09;
    localparam logic [OP_CNT_W-1:0]  BWORD_OP_TICKS   = 15'h0004;
    localparam logic [6:0]           BURST_MAX_WORDS  = 7'h40;
    localparam logic [4:0]           ERASE_PULSES     = 5'h10;
    localparam logic [OP_CNT_W-1:0]  SECTOR_OP_TICKS  = 15'h0FA0;
    localparam logic [OP_CNT_W-1:0]  PULSE_OP_TICKS   = OP_CNT_W'(SECTOR_OP_TICKS / 16);
    localparam int                   MASS_OP_TICKS    = 20000;
    localparam logic [BUS_CNT_W-1:0] BLANK_SETUP      = 5'h09;
    localparam int                   BLANK_WORDS      = 65536;

    typedef enum logic [2:0] {
        CMD_PROG_WORD  = 3'h0,
        CMD_PROG_BURST = 3'h1,
        CMD_SECTOR_ERA = 3'h2,
        CMD_MASS_ERA   = 3'h3,
        CMD_BLANK_CHK  = 3'h4
    } cmd_type;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_SETUP  = 2'h1,
        ST_OPWAIT = 2'h2,
        ST_CHECK  = 2'h3
    } state_type;

    typedef struct packed {
        logic    valid;
        cmd_type kind;
    } cmd_req_type;

    typedef struct packed {
        logic              ready;
        logic              busy;
        logic              done;
        logic              word_done;
        logic              pulse_done;
        logic              blank_fail;
        logic [ADDR_W-1:0] addr;
    } status_type;

endpackage

// File: rtl/op_clock_gen.sv
// Operation clock tick generator dividing the bus clock
module op_clock_gen #(
    parameter int DIV_W = 8
) (
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             restart_i,
    input  wire logic [DIV_W-1:0] op_clock_divider_i,
    output logic                  op_tick_o
);

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             tick;
    } gen_state_type;

    gen_state_type st_r;
    gen_state_type st_nxt;

    // One tick every divider+1 bus cycles
    always_comb begin
        st_nxt      = st_r;
        st_nxt.tick = 1'b0;
        if (restart_i) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt >= op_clock_divider_i) begin
            st_nxt.cnt  = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign op_tick_o = st_r.tick;

endmodule

// File: rtl/flash_program_erase_timing.sv
// Flash program, erase and blank-check sequencer
module flash_program_erase_timing #(
    parameter int MASS_OP_TICKS = flash_timing_pkg::MASS_OP_TICKS,
    parameter int BLANK_WORDS   = flash_timing_pkg::BLANK_WORDS
) (
    input  wire logic                                  clk_i,
    input  wire logic                                  sys_rst_i,
    input  wire flash_timing_pkg::cmd_req_type         cmd_i,
    input  wire logic [flash_timing_pkg::DIV_W-1:0]    op_clock_divider_i,
    input  wire logic                                  burst_next_i,
    input  wire logic                                  word_blank_i,
    output flash_timing_pkg::status_type               status_o
);

    localparam int CW = flash_timing_pkg::OP_CNT_W;
    localparam int AW = flash_timing_pkg::ADDR_W;

    typedef struct packed {
        flash_timing_pkg::state_type                     state;
        flash_timing_pkg::cmd_type                       kind;
        logic [flash_timing_pkg::BUS_CNT_W-1:0]          bus_cnt;
        logic [CW-1:0]                                   op_cnt;
        logic [6:0]                                      word_idx;
        logic [4:0]                                      pulse_idx;
        logic                                            restart;
        flash_timing_pkg::status_type                    stat;
    } seq_state_type;

    seq_state_type st_r;
    seq_state_type st_nxt;
    logic          op_tick;
    logic          accept;

    op_clock_gen #(
        .DIV_W(flash_timing_pkg::DIV_W)
    ) u_op_clock_gen (
        .clk_i              (clk_i),
        .sys_rst_i          (sys_rst_i),
        .restart_i          (st_r.restart),
        .op_clock_divider_i (op_clock_divider_i),
        .op_tick_o          (op_tick)
    );

    assign accept = cmd_i.valid && st_r.stat.ready;

    always_comb begin
        st_nxt                 = st_r;
        st_nxt.restart         = 1'b0;
        st_nxt.stat.done       = 1'b0;
        st_nxt.stat.word_done  = 1'b0;
        st_nxt.stat.pulse_done = 1'b0;
        unique case (st_r.state)
            flash_timing_pkg::ST_IDLE: begin
                // Divider value is never checked against limits
                if (accept) begin
                    st_nxt.kind            = cmd_i.kind;
                    st_nxt.state           = flash_timing_pkg::ST_SETUP;
                    st_nxt.word_idx        = '0;
                    st_nxt.pulse_idx       = '0;
                    st_nxt.stat.ready      = 1'b0;
                    st_nxt.stat.busy       = 1'b1;
                    st_nxt.stat.blank_fail = 1'b0;
                    st_nxt.stat.addr       = '0;
                    st_nxt.bus_cnt = flash_timing_pkg::SWORD_BUS_CYCLES - 1'b1;
                    unique case (cmd_i.kind)
                        flash_timing_pkg::CMD_SECTOR_ERA,
                        flash_timing_pkg::CMD_MASS_ERA: begin
                            // Erase setup is negligible: one cycle only
                            st_nxt.bus_cnt = '0;
                        end
                        flash_timing_pkg::CMD_BLANK_CHK: begin
                            st_nxt.bus_cnt = flash_timing_pkg::BLANK_SETUP - 1'b1;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            flash_timing_pkg::ST_SETUP: begin
                if (st_r.bus_cnt != '0) begin
                    st_nxt.bus_cnt = st_r.bus_cnt - 1'b1;
                end else if (st_r.kind == flash_timing_pkg::CMD_BLANK_CHK) begin
                    st_nxt.state = flash_timing_pkg::ST_CHECK;
                end else begin
                    st_nxt.state   = flash_timing_pkg::ST_OPWAIT;
                    st_nxt.restart = 1'b1;
                    unique case (st_r.kind)
                        // Sector erase split into equal pulses
                        flash_timing_pkg::CMD_SECTOR_ERA:
                            st_nxt.op_cnt = flash_timing_pkg::PULSE_OP_TICKS - 1'b1;
                        flash_timing_pkg::CMD_MASS_ERA:
                            st_nxt.op_cnt = CW'(MASS_OP_TICKS - 1);
                        default: begin
                            if (st_r.word_idx != '0) begin
                                st_nxt.op_cnt = flash_timing_pkg::BWORD_OP_TICKS - 1'b1;
                            end else begin
                                st_nxt.op_cnt = flash_timing_pkg::SWORD_OP_TICKS - 1'b1;
                            end
                        end
                    endcase
                end
            end
            flash_timing_pkg::ST_OPWAIT: begin
                // Operation phase counts divided clock ticks
                if (op_tick && !st_r.restart) begin
                    if (st_r.op_cnt != '0) begin
                        st_nxt.op_cnt = st_r.op_cnt - 1'b1;
                    end else if (st_r.kind == flash_timing_pkg::CMD_SECTOR_ERA) begin
                        st_nxt.stat.pulse_done = 1'b1;
                        if (st_r.pulse_idx == flash_timing_pkg::ERASE_PULSES - 1'b1) begin
                            st_nxt.state      = flash_timing_pkg::ST_IDLE;
                            st_nxt.stat.done  = 1'b1;
                            st_nxt.stat.ready = 1'b1;
                            st_nxt.stat.busy  = 1'b0;
                        end else begin
                            st_nxt.pulse_idx = st_r.pulse_idx + 1'b1;
                            st_nxt.op_cnt    = flash_timing_pkg::PULSE_OP_TICKS - 1'b1;
                            st_nxt.restart   = 1'b1;
                        end
                    end else if (st_r.kind == flash_timing_pkg::CMD_PROG_BURST &&
                                 burst_next_i &&
                                 st_r.word_idx != flash_timing_pkg::BURST_MAX_WORDS - 1'b1) begin
                        // Refilled pipeline keeps the burst going
                        // Row ends after 63 further words
                        st_nxt.stat.word_done = 1'b1;
                        st_nxt.word_idx       = st_r.word_idx + 1'b1;
                        st_nxt.stat.addr      = st_r.stat.addr + 1'b1;
                        st_nxt.state          = flash_timing_pkg::ST_SETUP;
                        st_nxt.bus_cnt = flash_timing_pkg::BWORD_BUS_CYCLES - 1'b1;
                    end else begin
                        st_nxt.stat.word_done = (st_r.kind != flash_timing_pkg::CMD_MASS_ERA);
                        st_nxt.state          = flash_timing_pkg::ST_IDLE;
                        st_nxt.stat.done      = 1'b1;
                        st_nxt.stat.ready     = 1'b1;
                        st_nxt.stat.busy      = 1'b0;
                    end
                end
            end
            flash_timing_pkg::ST_CHECK: begin
                // One word per bus cycle, stop at first non-blank
                if (!word_blank_i || st_r.stat.addr == AW'(BLANK_WORDS - 1)) begin
                    st_nxt.state           = flash_timing_pkg::ST_IDLE;
                    st_nxt.stat.done       = 1'b1;
                    st_nxt.stat.ready      = 1'b1;
                    st_nxt.stat.busy       = 1'b0;
                    st_nxt.stat.blank_fail = !word_blank_i;
                end else begin
                    st_nxt.stat.addr = st_r.stat.addr + 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_r            <= '0;
            st_r.stat.ready <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign status_o = st_r.stat;

    // Helper: erase pulses seen since the command was taken
    logic [4:0] pulses_seen;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pulses_seen <= '0;
        end else if (accept) begin
            pulses_seen <= '0;
        end else if (st_r.stat.pulse_done) begin
            pulses_seen <= pulses_seen + 1'b1;
        end
    end

    property p_busy_not_ready;
        @(posedge clk_i) disable iff (sys_rst_i)
        st_r.state != flash_timing_pkg::ST_IDLE |-> !status_o.ready && status_o.busy;
    endproperty
    a_busy_not_ready: assert property (p_busy_not_ready)
        else $error("ready seen while an operation runs");

    property p_done_reopens;
        @(posedge clk_i) disable iff (sys_rst_i)
        status_o.done |-> status_o.ready ##1 !status_o.done;
    endproperty
    a_done_reopens: assert property (p_done_reopens)
        else $error("done without ready or longer than one cycle");

    property p_word_setup;
        @(posedge clk_i) disable iff (sys_rst_i)
        accept && cmd_i.kind == flash_timing_pkg::CMD_PROG_WORD
        |=> (st_r.state == flash_timing_pkg::ST_SETUP)[*8] ##17
            st_r.state == flash_timing_pkg::ST_SETUP ##1
            st_r.state == flash_timing_pkg::ST_OPWAIT;
    endproperty
    a_word_setup: assert property (p_word_setup)
        else $error("single word bus phase is not 25 cycles");

    property p_burst_word_setup;
        @(posedge clk_i) disable iff (sys_rst_i)
        st_r.stat.word_done && st_r.state == flash_timing_pkg::ST_SETUP
        |-> ##8 st_r.state == flash_timing_pkg::ST_SETUP ##1
            st_r.state == flash_timing_pkg::ST_OPWAIT && st_r.op_cnt == 15'h0003;
    endproperty
    a_burst_word_setup: assert property (p_burst_word_setup)
        else $error("burst word timing wrong");

    property p_burst_limit;
        @(posedge clk_i) disable iff (sys_rst_i)
        st_r.word_idx == 7'h3F |=> st_r.word_idx != 7'h40;
    endproperty
    a_burst_limit: assert property (p_burst_limit)
        else $error("burst exceeded 64 words");

    property p_op_end;
        @(posedge clk_i) disable iff (sys_rst_i)
        st_r.state == flash_timing_pkg::ST_OPWAIT && op_tick && !st_r.restart &&
        st_r.op_cnt != '0 |=> st_r.state == flash_timing_pkg::ST_OPWAIT;
    endproperty
    a_op_end: assert property (p_op_end)
        else $error("operation phase left before its ticks ran out");

    property p_sector_pulses;
        @(posedge clk_i) disable iff (sys_rst_i)
        status_o.done && st_r.kind == flash_timing_pkg::CMD_SECTOR_ERA
        |-> pulses_seen == 5'h0F && status_o.pulse_done;
    endproperty
    a_sector_pulses: assert property (p_sector_pulses)
        else $error("sector erase did not give 16 pulses");

    property p_blank_first;
        @(posedge clk_i) disable iff (sys_rst_i)
        accept && cmd_i.kind == flash_timing_pkg::CMD_BLANK_CHK
        |-> ##10 st_r.state == flash_timing_pkg::ST_CHECK && st_r.stat.addr == '0;
    endproperty
    a_blank_first: assert property (p_blank_first)
        else $error("blank check scan does not start at cycle 10");

    property p_blank_stop;
        @(posedge clk_i) disable iff (sys_rst_i)
        st_r.state == flash_timing_pkg::ST_CHECK && !word_blank_i
        |=> status_o.done && status_o.blank_fail && status_o.addr == $past(st_r.stat.addr);
    endproperty
    a_blank_stop: assert property (p_blank_stop)
        else $error("blank check did not stop at the non-blank word");

    c_word_done:  cover property (@(posedge clk_i) disable iff (sys_rst_i)
        status_o.done && st_r.kind == flash_timing_pkg::CMD_PROG_WORD);
    c_burst_two:  cover property (@(posedge clk_i) disable iff (sys_rst_i)
        status_o.done && st_r.word_idx == 7'h01);
    c_sector:     cover property (@(posedge clk_i) disable iff (sys_rst_i)
        status_o.done && st_r.kind == flash_timing_pkg::CMD_SECTOR_ERA);
    c_blank_fail: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        status_o.done && status_o.blank_fail);

endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the flash program, erase and blank-check sequencer
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // Shortened counts keep the run brief; expectations derive from these
    localparam int MASS_T  = 20;
    localparam int BLANK_N = 16;

    logic                          clk_i        = 1'b0;
    logic                          sys_rst_i    = 1'b1;
    flash_timing_pkg::cmd_req_type cmd_i        = '0;
    logic [7:0]                    div_r        = 8'h00;
    logic                          burst_next_i = 1'b0;
    logic                          word_blank_i = 1'b1;
    flash_timing_pkg::status_type  status_o;
    int                            err_total    = 0;
    int                            comparisons  = 0;
    logic [16:0]                   fail_addr    = 17'h1FFFF;
    logic                          poke         = 1'b0;
    logic                          one_more     = 1'b0;
    int                            cyc;
    int                            n_word;
    int                            n_pulse;

    always #20 clk_i = ~clk_i;

    flash_program_erase_timing #(
        .MASS_OP_TICKS (MASS_T),
        .BLANK_WORDS   (BLANK_N)
    ) dut_u (
        .clk_i              (clk_i),
        .sys_rst_i          (sys_rst_i),
        .cmd_i              (cmd_i),
        .op_clock_divider_i (div_r),
        .burst_next_i       (burst_next_i),
        .word_blank_i       (word_blank_i),
        .status_o           (status_o)
    );

    task automatic conclude;
        $display("Counts: comparisons=%0d mismatches=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_range(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    // Issues one command and counts cycles from the accept edge up to done
    task automatic run_cmd(input flash_timing_pkg::cmd_type k, input int limit);
        int n;
        @(negedge clk_i);
        cmd_i.kind  = k;
        cmd_i.valid = 1'b1;
        @(negedge clk_i);
        cmd_i.valid = 1'b0;
        n_word  = 0;
        n_pulse = 0;
        check_val({30'h0, status_o.busy, status_o.ready}, 32'h2);
        n = 1;
        while (status_o.done !== 1'b1) begin
            n_word  += int'(status_o.word_done);
            n_pulse += int'(status_o.pulse_done);
            if (n >= limit) begin
                check_val(32'h0, 32'h1);
                conclude();
            end
            @(negedge clk_i);
            n++;
            // Requests while busy must be ignored without trace
            if (poke) begin
                cmd_i.kind  = flash_timing_pkg::CMD_BLANK_CHK;
                cmd_i.valid = (n > 1 && n < 6);
            end
            // Pipeline runs dry after one word
            if (one_more && status_o.word_done) begin
                burst_next_i = 1'b0;
            end
            word_blank_i = (status_o.addr != fail_addr);
        end
        n_word  += int'(status_o.word_done);
        n_pulse += int'(status_o.pulse_done);
        cyc = n;
        check_val({31'h0, status_o.ready}, 32'h1);
    endtask

    task automatic test_reset;
        @(negedge clk_i);
        check_val({29'h0, status_o.ready, status_o.busy, status_o.done}, 32'h4);
        $display("Test reset done");
    endtask

    task automatic test_blank;
        fail_addr = 17'h00000;
        run_cmd(flash_timing_pkg::CMD_BLANK_CHK, 100);
        check_val(cyc, 11);
        check_val({14'h0, status_o.blank_fail, status_o.addr}, 32'h20000);
        fail_addr = 17'h00005;
        run_cmd(flash_timing_pkg::CMD_BLANK_CHK, 100);
        check_val(cyc, 16);
        check_val({14'h0, status_o.blank_fail, status_o.addr}, 32'h20005);
        fail_addr = 17'h1FFFF;
        run_cmd(flash_timing_pkg::CMD_BLANK_CHK, 200);
        check_val(cyc, BLANK_N + 10);
        check_val({31'h0, status_o.blank_fail}, 32'h0);
        $display("Test blank check done");
    endtask

    task automatic test_prog_word;
        logic [7:0] divs [4];
        int         lo;
        divs = '{8'h00, 8'h03, 8'h7C, 8'hFF};
        foreach (divs[i]) begin
            div_r = divs[i];
            lo = 26 + 9 * (int'(divs[i]) + 1);
            run_cmd(flash_timing_pkg::CMD_PROG_WORD, 5000);
            check_range(cyc, lo, lo + 4);
            check_val(n_word, 1);
        end
        $display("Test single word done");
    endtask

    task automatic test_burst;
        int lo;
        div_r = 8'h00;
        burst_next_i = 1'b1;
        lo = 26 + 9 + 63 * (9 + 4);
        run_cmd(flash_timing_pkg::CMD_PROG_BURST, 3000);
        check_val(n_word, 64);
        check_range(cyc, lo, lo + 2 * 64 + 4);
        check_val({15'h0, status_o.addr}, 32'h3F);
        one_more = 1'b1;
        lo = 26 + 9 + (9 + 4);
        run_cmd(flash_timing_pkg::CMD_PROG_BURST, 3000);
        one_more = 1'b0;
        burst_next_i = 1'b0;
        check_val(n_word, 2);
        check_range(cyc, lo, lo + 2 * 2 + 4);
        check_val({15'h0, status_o.addr}, 32'h1);
        $display("Test burst done");
    endtask

    task automatic test_sector;
        int lo;
        div_r = 8'h00;
        lo = 1 + 16 * 250;
        run_cmd(flash_timing_pkg::CMD_SECTOR_ERA, 6000);
        check_val(n_pulse, 16);
        check_range(cyc, lo, lo + 2 * 16 + 4);
        $display("Test sector erase done");
    endtask

    task automatic test_mass;
        int lo;
        div_r = 8'h01;
        poke = 1'b1;
        lo = 1 + MASS_T * 2;
        run_cmd(flash_timing_pkg::CMD_MASS_ERA, 500);
        poke = 1'b0;
        cmd_i.valid = 1'b0;
        check_range(cyc, lo, lo + 4);
        check_val({31'h0, status_o.blank_fail}, 32'h0);
        $display("Test mass erase done");
    endtask

    // Reset in mid-scan must reopen the port and clear the scan address
    task automatic test_mid_reset;
        fail_addr = 17'h1FFFF;
        @(negedge clk_i);
        cmd_i.kind  = flash_timing_pkg::CMD_BLANK_CHK;
        cmd_i.valid = 1'b1;
        @(negedge clk_i);
        cmd_i.valid = 1'b0;
        repeat (14) @(negedge clk_i);
        check_val({15'h0, status_o.addr}, 32'h5);
        sys_rst_i = 1'b1;
        @(negedge clk_i);
        check_val({29'h0, status_o.ready, status_o.busy, status_o.done}, 32'h4);
        check_val({15'h0, status_o.addr}, 32'h0);
        sys_rst_i = 1'b0;
        run_cmd(flash_timing_pkg::CMD_BLANK_CHK, 200);
        check_val(cyc, BLANK_N + 10);
        $display("Test mid-run reset done");
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        test_reset();
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        test_blank();
        test_prog_word();
        test_burst();
        test_sector();
        test_mass();
        test_mid_reset();
        conclude();
    end
endmodule
